// ==== include/bmt_consts.svh ====
`ifndef BMT_CONSTS_SVH
`define BMT_CONSTS_SVH

// Register byte offsets on the APB bus.
`define BMT_OFS_CONTROL     16'h8000
`define BMT_OFS_STATUS      16'h8004
`define BMT_OFS_OPERATION   16'h8008
`define BMT_OFS_SRC_START   16'h800c
`define BMT_OFS_DST_START   16'h8010
`define BMT_OFS_STRIDE      16'h8014
`define BMT_OFS_WIDTH       16'h8018
`define BMT_OFS_HEIGHT      16'h801c
`define BMT_OFS_BG_COLOUR   16'h8020
`define BMT_OFS_DATA_PORT   16'h8100

// Control register fields.
`define BMT_CTL_START       0
`define BMT_CTL_DST_LINEAR  1
`define BMT_CTL_SRC_LINEAR  2
`define BMT_CTL_BPP16       18

// Status register fields.
`define BMT_STS_ACTIVE      0
`define BMT_STS_FULL        4
`define BMT_STS_HALF        5
`define BMT_STS_NOT_EMPTY   6

// Operation register fields and codes.
`define BMT_OP_LSB          0
`define BMT_OP_MSB          3
`define BMT_ROP_LSB         16
`define BMT_ROP_MSB         19
`define BMT_OPC_MOVE_POS    4'h2
`define BMT_OPC_MOVE_NEG    4'h3
`define BMT_OPC_TWRITE      4'h4

// Reset value of every parameter register.
`define BMT_REG_RESET       32'h0000_0000

`endif

// ==== include/bmt_pkg.sv ====
package bmt_pkg;

	// Engine sequencer states.
	typedef enum logic [2:0] {
		bmt_idle,
		bmt_src_rd,
		bmt_dst_rd,
		bmt_fetch,
		bmt_tpix,
		bmt_wr,
		bmt_next
	} bmt_state_t;

	// One display memory command, held until acknowledged.
	typedef struct packed {
		logic        we;
		logic [17:0] addr;
		logic [15:0] wdata;
		logic [1:0]  be;
	} bmt_mem_cmd_t;

endpackage : bmt_pkg

// ==== rtl/bmt_engine.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "bmt_consts.svh"
// Summary of operation
// R01: Move copies source area to destination area.
// R02: Started move runs to completion unaided.
// R03: Op code 2h positive move, 3h negative.
// R04: ROP bits 19-16 combine source, destination.
// R05: Control bit 18 selects 16 or 8 bpp.
// R06: Writing control bit 0 starts the operation.
// R07: Width and height hold count minus one.
// R08: Row stride given in words, added per row.
// R09: Linear select zero means rectangular addressing.
// R10: Negative move walks back from last pixel.
// R11: Host picks negative move for upward overlap.
// R12: Parameters latched only when start is written.
// R13: Transparent colour pixels skipped, no ROP.
// R14: Transparent write ends after last pixel.
// R15: Data accepted as 16-bit words only.
// R16: At 16 bpp one word per pixel.
// R17: Source bit 0 sets byte phase.
// R18: Words per row (width+1+phase)/2, last low.
// R19: Op code 4h transparent write, background key.
// R20: FIFO full, half, not empty in status.
// R21: Status bit 0 high while operation active.
// R22: Positive move walks increasing addresses, rows down.
// R23: After last pixel engine clears active, idles.
module bmt_engine #(
	parameter int ADDR_W = 18,	// Display buffer byte address width.
	parameter int DIM_W  = 10,	// Width and height field width.
	parameter int DEPTH  = 16	// Data FIFO depth in words.
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [15:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output      logic [31:0]         prdata,
	output      logic                pready,
	output      logic                pslverr,
	output      logic                mem_valid,
	output      bmt_pkg::bmt_mem_cmd_t mem_cmd,
	input  wire logic                mem_ack,
	input  wire logic [15:0]         mem_rdata
);

	localparam int CW = $clog2(DEPTH + 1);	// FIFO count width.
	localparam int PW = $clog2(DEPTH);	// FIFO pointer width.

	// Software visible parameter registers.
	logic [31:0]       control_reg;	// Bpp and linear selects.
	logic [31:0]       operation_reg;	// Operation and ROP code.
	logic [31:0]       src_start_reg;	// Source start byte address.
	logic [31:0]       dst_start_reg;	// Destination start byte address.
	logic [31:0]       stride_reg;	// Row stride in 16-bit words.
	logic [31:0]       width_reg;	// Pixels per row minus one.
	logic [31:0]       height_reg;	// Rows minus one.
	logic [31:0]       bg_reg;	// Transparent key colour.

	// Data FIFO storage and pointers.
	logic [15:0]       fifo_mem [DEPTH];	// Word storage.
	logic [PW-1:0]     wptr_reg;	// Write pointer.
	logic [PW-1:0]     rptr_reg;	// Read pointer.
	logic [CW-1:0]     count_reg;	// Words held.

	// Engine state, latched at start.
	bmt_pkg::bmt_state_t state_reg;	// Sequencer state.
	logic              active_reg;	// Operation in progress.
	logic              is_tw_reg;	// Transparent write running.
	logic              neg_reg;	// Backward walk.
	logic              bpp16_reg;	// Sixteen bits per pixel.
	logic              src_lin_reg;	// Source is linear.
	logic              dst_lin_reg;	// Destination is linear.
	logic [3:0]        rop_reg;	// Raster operation.
	logic [15:0]       key_reg;	// Transparent colour.
	logic [DIM_W-1:0]  wlast_reg;	// Last column index.
	logic [DIM_W-1:0]  hlast_reg;	// Last row index.
	logic [DIM_W-1:0]  x_reg;	// Current column.
	logic [DIM_W-1:0]  y_reg;	// Current row.
	logic [ADDR_W-1:0] pitch_reg;	// Row pitch in bytes.
	logic [ADDR_W-1:0] src_cur_reg;	// Source pixel address.
	logic [ADDR_W-1:0] src_row_reg;	// Source row start.
	logic [ADDR_W-1:0] dst_cur_reg;	// Destination pixel address.
	logic [ADDR_W-1:0] dst_row_reg;	// Destination row start.
	logic [15:0]       spix_reg;	// Source pixel.
	logic [15:0]       hold_reg;	// Word popped from FIFO.
	logic              have_reg;	// Held word still has pixels.
	logic              sel_reg;	// Byte lane of next 8 bpp pixel.
	logic              phase_reg;	// Source byte phase.

	// Bus decode and engine helpers.
	logic              acc;	// Access phase seen.
	logic              wr_done;	// Write takes effect now.
	logic              is_data;	// Address hits the data port.
	logic              mapped;	// Address hits any register.
	logic              full;	// FIFO full.
	logic              push;	// Word enters the FIFO.
	logic              pop;	// Word leaves the FIFO.
	logic              start;	// Valid start request.
	logic [3:0]        opc;	// Operation code being started.
	logic [ADDR_W-1:0] step;	// Pixel size in bytes.
	logic [15:0]       tpix;	// Current transparent write pixel.
	logic [15:0]       rop_out;	// ROP result.
	logic [ADDR_W-1:0] src_nrow;	// Next source row start.
	logic [ADDR_W-1:0] dst_nrow;	// Next destination row start.

	// Picks the pixel out of a memory word by its byte address.
	function automatic logic [15:0] bmt_pick(input logic [15:0] w,
		input logic odd, input logic wide);
		if (wide) begin
			bmt_pick = w;
		end else begin
			bmt_pick = {8'h00, odd ? w[15:8] : w[7:0]};
		end
	endfunction : bmt_pick

	// Applies the raster code bitwise, indexed by source and dest.
	function automatic logic [15:0] bmt_rop(input logic [3:0] code,
		input logic [15:0] s, input logic [15:0] d);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = code[{s[i], d[i]}];
		end
		bmt_rop = r;
	endfunction : bmt_rop

	// Decode and handshake terms for the APB slave.
	always_comb begin
		acc     = psel && penable;
		wr_done = acc && pready && pwrite;
		is_data = paddr == `BMT_OFS_DATA_PORT;
		mapped  = is_data || paddr == `BMT_OFS_CONTROL ||
			paddr == `BMT_OFS_STATUS || paddr == `BMT_OFS_OPERATION ||
			paddr == `BMT_OFS_SRC_START || paddr == `BMT_OFS_DST_START ||
			paddr == `BMT_OFS_STRIDE || paddr == `BMT_OFS_WIDTH ||
			paddr == `BMT_OFS_HEIGHT || paddr == `BMT_OFS_BG_COLOUR;
		full    = count_reg == CW'(DEPTH);
		// Only the low 16 bits of a data port write form a word.
		push    = wr_done && is_data && is_tw_reg && !full; // R15
		opc     = operation_reg[`BMT_OP_MSB:`BMT_OP_LSB];
		start   = wr_done && paddr == `BMT_OFS_CONTROL &&
			pwdata[`BMT_CTL_START] && !active_reg &&
			(opc == `BMT_OPC_MOVE_POS || opc == `BMT_OPC_MOVE_NEG ||
			opc == `BMT_OPC_TWRITE); // R06
		pop     = state_reg == bmt_pkg::bmt_fetch && !have_reg &&
			count_reg != '0;
	end

	// APB answer: one wait state, data port writes stall while FIFO full in a transparent write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (acc && !pready) begin
			if (!(is_data && pwrite && is_tw_reg && full)) begin // R20
				pready  <= 1'b1;
				pslverr <= !mapped;
				prdata  <= 32'h0000_0000;
				if (!pwrite) begin
					unique case (paddr)
						`BMT_OFS_CONTROL:   prdata <= control_reg;
						`BMT_OFS_STATUS: begin
							prdata[`BMT_STS_ACTIVE]    <= active_reg; // R21
							prdata[`BMT_STS_FULL]      <= full; // R20
							prdata[`BMT_STS_HALF]      <=
								count_reg >= CW'(DEPTH / 2); // R20
							prdata[`BMT_STS_NOT_EMPTY] <=
								count_reg != '0; // R20
						end
						`BMT_OFS_OPERATION: prdata <= operation_reg;
						`BMT_OFS_SRC_START: prdata <= src_start_reg;
						`BMT_OFS_DST_START: prdata <= dst_start_reg;
						`BMT_OFS_STRIDE:    prdata <= stride_reg;
						`BMT_OFS_WIDTH:     prdata <= width_reg;
						`BMT_OFS_HEIGHT:    prdata <= height_reg;
						`BMT_OFS_BG_COLOUR: prdata <= bg_reg;
						default:            prdata <= 32'h0000_0000;
					endcase
				end
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Parameter registers, writable in any order at any time.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_reg   <= `BMT_REG_RESET;
			operation_reg <= `BMT_REG_RESET;
			src_start_reg <= `BMT_REG_RESET;
			dst_start_reg <= `BMT_REG_RESET;
			stride_reg    <= `BMT_REG_RESET;
			width_reg     <= `BMT_REG_RESET;
			height_reg    <= `BMT_REG_RESET;
			bg_reg        <= `BMT_REG_RESET;
		end else if (wr_done) begin
			unique case (paddr)
				`BMT_OFS_CONTROL: begin
					// The start bit itself is not stored.
					control_reg                 <= pwdata;
					control_reg[`BMT_CTL_START] <= 1'b0;
				end
				`BMT_OFS_OPERATION: operation_reg <= pwdata;
				`BMT_OFS_SRC_START: src_start_reg <= pwdata;
				`BMT_OFS_DST_START: dst_start_reg <= pwdata;
				`BMT_OFS_STRIDE:    stride_reg    <= pwdata;
				`BMT_OFS_WIDTH:     width_reg     <= pwdata;
				`BMT_OFS_HEIGHT:    height_reg    <= pwdata;
				`BMT_OFS_BG_COLOUR: bg_reg        <= pwdata;
				default: ;
			endcase
		end
	end

	// Data FIFO; a start empties it so no stale words are used.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else if (start) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end

	// FIFO storage needs no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem[wptr_reg] <= pwdata[15:0]; // R15
		end
	end

	// Address stepping and pixel datapath.
	always_comb begin
		step     = bpp16_reg ? ADDR_W'(2) : ADDR_W'(1); // R05
		tpix     = bmt_pick(hold_reg, sel_reg, bpp16_reg); // R17
		rop_out  = bmt_rop(rop_reg, spix_reg,
			bmt_pick(mem_rdata, dst_cur_reg[0], bpp16_reg)); // R04
		src_nrow = neg_reg ? src_row_reg - pitch_reg
			: src_row_reg + pitch_reg; // R08
		dst_nrow = neg_reg ? dst_row_reg - pitch_reg
			: dst_row_reg + pitch_reg; // R08
	end

	// Sequencer: walks rows and columns, issues memory commands.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg   <= bmt_pkg::bmt_idle;
			active_reg  <= 1'b0;
			is_tw_reg   <= 1'b0;
			neg_reg     <= 1'b0;
			bpp16_reg   <= 1'b0;
			src_lin_reg <= 1'b0;
			dst_lin_reg <= 1'b0;
			rop_reg     <= 4'h0;
			key_reg     <= 16'h0000;
			wlast_reg   <= '0;
			hlast_reg   <= '0;
			x_reg       <= '0;
			y_reg       <= '0;
			pitch_reg   <= '0;
			src_cur_reg <= '0;
			src_row_reg <= '0;
			dst_cur_reg <= '0;
			dst_row_reg <= '0;
			spix_reg    <= 16'h0000;
			hold_reg    <= 16'h0000;
			have_reg    <= 1'b0;
			sel_reg     <= 1'b0;
			phase_reg   <= 1'b0;
			mem_valid   <= 1'b0;
			mem_cmd     <= '0;
		end else begin
			unique case (state_reg)
				bmt_pkg::bmt_idle: begin
					if (start) begin
						// Snapshot every parameter at the start write.
						active_reg  <= 1'b1; // R12
						is_tw_reg   <= opc == `BMT_OPC_TWRITE; // R19
						neg_reg     <= opc == `BMT_OPC_MOVE_NEG; // R03
						bpp16_reg   <= pwdata[`BMT_CTL_BPP16]; // R05
						dst_lin_reg <= pwdata[`BMT_CTL_DST_LINEAR]; // R09
						src_lin_reg <= pwdata[`BMT_CTL_SRC_LINEAR]; // R09
						rop_reg     <= operation_reg[`BMT_ROP_MSB:
							`BMT_ROP_LSB]; // R04
						key_reg     <= bg_reg[15:0]; // R19
						wlast_reg   <= width_reg[DIM_W-1:0]; // R07
						hlast_reg   <= height_reg[DIM_W-1:0]; // R07
						x_reg       <= '0;
						y_reg       <= '0;
						pitch_reg   <= {stride_reg[ADDR_W-2:0], 1'b0}; // R08
						src_cur_reg <= src_start_reg[ADDR_W-1:0]; // R10
						src_row_reg <= src_start_reg[ADDR_W-1:0]; // R10
						dst_cur_reg <= dst_start_reg[ADDR_W-1:0]; // R10
						dst_row_reg <= dst_start_reg[ADDR_W-1:0]; // R10
						phase_reg   <= src_start_reg[0]; // R17
						sel_reg     <= src_start_reg[0]; // R17
						have_reg    <= 1'b0;
						state_reg   <= opc == `BMT_OPC_TWRITE ?
							bmt_pkg::bmt_fetch : bmt_pkg::bmt_src_rd; // R02
					end
				end
				bmt_pkg::bmt_src_rd: begin
					if (!mem_valid) begin
						mem_valid     <= 1'b1;
						mem_cmd.we    <= 1'b0;
						mem_cmd.addr  <= src_cur_reg; // R01
						mem_cmd.wdata <= 16'h0000;
						mem_cmd.be    <= 2'b11;
					end else if (mem_ack) begin
						mem_valid <= 1'b0;
						spix_reg  <= bmt_pick(mem_rdata, src_cur_reg[0],
							bpp16_reg);
						state_reg <= bmt_pkg::bmt_dst_rd;
					end
				end
				bmt_pkg::bmt_dst_rd: begin
					if (!mem_valid) begin
						mem_valid    <= 1'b1;
						mem_cmd.we   <= 1'b0;
						mem_cmd.addr <= dst_cur_reg;
					end else if (mem_ack) begin
						mem_valid <= 1'b0;
						spix_reg  <= rop_out; // R04
						state_reg <= bmt_pkg::bmt_wr;
					end
				end
				bmt_pkg::bmt_fetch: begin
					// Waits on the host for the next data word.
					if (pop) begin
						hold_reg  <= fifo_mem[rptr_reg];
						have_reg  <= 1'b1;
						state_reg <= bmt_pkg::bmt_tpix;
					end else if (have_reg) begin
						state_reg <= bmt_pkg::bmt_tpix;
					end
				end
				bmt_pkg::bmt_tpix: begin
					// Key colour pixels leave the destination alone.
					spix_reg  <= tpix; // R13
					state_reg <= tpix == (bpp16_reg ? key_reg :
						{8'h00, key_reg[7:0]}) ?
						bmt_pkg::bmt_next : bmt_pkg::bmt_wr; // R13
				end
				bmt_pkg::bmt_wr: begin
					if (!mem_valid) begin
						mem_valid     <= 1'b1;
						mem_cmd.we    <= 1'b1;
						mem_cmd.addr  <= dst_cur_reg;
						mem_cmd.wdata <= bpp16_reg ? spix_reg :
							{spix_reg[7:0], spix_reg[7:0]};
						mem_cmd.be    <= bpp16_reg ? 2'b11 :
							(dst_cur_reg[0] ? 2'b10 : 2'b01);
					end else if (mem_ack) begin
						mem_valid <= 1'b0;
						state_reg <= bmt_pkg::bmt_next;
					end
				end
				bmt_pkg::bmt_next: begin
					if (x_reg != wlast_reg) begin
						// Next pixel in the row, forward or back.
						x_reg       <= x_reg + 1'b1;
						src_cur_reg <= neg_reg ? src_cur_reg - step
							: src_cur_reg + step; // R22
						dst_cur_reg <= neg_reg ? dst_cur_reg - step
							: dst_cur_reg + step; // R10
						if (bpp16_reg || sel_reg) begin
							have_reg <= 1'b0; // R16
							sel_reg  <= 1'b0;
						end else begin
							sel_reg <= 1'b1; // R18
						end
						state_reg <= is_tw_reg ? bmt_pkg::bmt_fetch
							: bmt_pkg::bmt_src_rd;
					end else if (y_reg == hlast_reg) begin
						active_reg <= 1'b0; // R23
						is_tw_reg  <= 1'b0; // R14
						state_reg  <= bmt_pkg::bmt_idle; // R23
					end else begin
						// New row: leftover byte of the last word dropped.
						x_reg       <= '0;
						y_reg       <= y_reg + 1'b1;
						have_reg    <= 1'b0; // R18
						sel_reg     <= phase_reg; // R17
						src_row_reg <= src_nrow;
						dst_row_reg <= dst_nrow;
						if (src_lin_reg) begin
							src_cur_reg <= neg_reg ? src_cur_reg - step
								: src_cur_reg + step; // R09
						end else begin
							src_cur_reg <= src_nrow; // R09
						end
						if (dst_lin_reg) begin
							dst_cur_reg <= neg_reg ? dst_cur_reg - step
								: dst_cur_reg + step; // R09
						end else begin
							dst_cur_reg <= dst_nrow; // R09
						end
						state_reg <= is_tw_reg ? bmt_pkg::bmt_fetch
							: bmt_pkg::bmt_src_rd;
					end
				end
			endcase
		end
	end

endmodule : bmt_engine

// ==== tb/bmt_engine_monitor.sv ====
`timescale 1ns/1ns
`include "bmt_consts.svh"
// Port checker for the blit engine.
module bmt_engine_monitor (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [15:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  mem_valid,
	input wire bmt_pkg::bmt_mem_cmd_t mem_cmd,
	input wire logic                  mem_ack,
	input wire logic [15:0]           mem_rdata
);
	logic hole;	// High when paddr names no register.
	assign hole = !((paddr >= 16'h8000 && paddr <= 16'h8020 &&
		paddr[1:0] == 2'b00) || paddr == `BMT_OFS_DATA_PORT);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// First access cycle of a register transfer.
	sequence s_access;
		psel && penable && !pready && $rose(penable) &&
			paddr != `BMT_OFS_DATA_PORT;
	endsequence
	// A memory command still waiting for its acknowledge.
	sequence s_mem_wait;
		mem_valid && !mem_ack;
	endsequence
	property p_one_wait; s_access |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_in_access; pready |-> psel && penable; endproperty
	property p_hole; pready && hole |-> pslverr; endproperty
	property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
	property p_start_rd;
		pready && !pwrite && paddr == `BMT_OFS_CONTROL |-> !prdata[0];
	endproperty
	property p_port_rd;
		pready && !pwrite && paddr == `BMT_OFS_DATA_PORT |-> prdata == 32'h0;
	endproperty
	property p_mem_hold; s_mem_wait |=> mem_valid && $stable(mem_cmd);
	endproperty
	property p_mem_drop; mem_valid && mem_ack |=> !mem_valid; endproperty
	property p_lane;
		mem_valid && mem_cmd.we && mem_cmd.be != 2'b11 |->
			mem_cmd.be == {mem_cmd.addr[0], !mem_cmd.addr[0]} &&
			mem_cmd.wdata[15:8] == mem_cmd.wdata[7:0];
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("No answer after one wait state");
	a_pulse: assert property (p_pulse)
		else $error("Ready longer than one cycle");
	a_in_access: assert property (p_in_access)
		else $error("Ready outside an access");
	a_hole: assert property (p_hole)
		else $error("Unmapped access without error");
	a_wr_zero: assert property (p_wr_zero)
		else $error("Read data not zero on write");
	a_start_rd: assert property (p_start_rd)
		else $error("Start bit reads one");
	a_port_rd: assert property (p_port_rd)
		else $error("Data port read not zero");
	a_mem_hold: assert property (p_mem_hold)
		else $error("Memory command changed before acknowledge");
	a_mem_drop: assert property (p_mem_drop)
		else $error("Memory valid held after acknowledge");
	a_lane: assert property (p_lane)
		else $error("Byte lane does not match address");
endmodule : bmt_engine_monitor

bind bmt_engine bmt_engine_monitor mon_u (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
	.mem_rdata(mem_rdata));

// ==== tb/bmt_engine_tb_top.sv ====
`timescale 1ns/1ns
`include "bmt_consts.svh"
// Register-level tests of moves and transparent writes.
module bmt_engine_tb_top;
	logic                  clk, rst, psel, penable, pwrite, slow;
	logic [15:0]           paddr;
	logic [31:0]           pwdata, prdata, rd_q;
	logic                  pready, pslverr, err_q, mem_valid, mem_ack;
	bmt_pkg::bmt_mem_cmd_t mem_cmd;
	logic [15:0]           mem_rdata;
	int                    mismatches, checked;
	localparam logic [15:0] reg_list [6] = '{16'h800c, 16'h8010,
		16'h8014, 16'h8018, 16'h801c, 16'h8020};
	localparam logic [15:0] tw_data [4] = '{16'hee11, 16'h337c,
		16'hdd44, 16'h6655};	// Phase 1, key colour in the second pixel.
	localparam logic [15:0] tw_exp [4] = '{16'hffee, 16'hff33,
		16'h55dd, 16'hff66};
	localparam int tw_idx [4] = '{256, 257, 264, 265};

	bmt_engine dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_valid(mem_valid),
		.mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	bmt_mem_model mem_u (.clk(clk), .rst(rst), .slow(slow),
		.mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	// 100 ns clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic wr, input logic [15:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Compare one value and count the outcome.
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Program the area registers.
	task automatic setup(input logic [31:0] s, t, st, w, h);
		apb(1'b1, `BMT_OFS_SRC_START, s);
		apb(1'b1, `BMT_OFS_DST_START, t);
		apb(1'b1, `BMT_OFS_STRIDE, st);
		apb(1'b1, `BMT_OFS_WIDTH, w);
		apb(1'b1, `BMT_OFS_HEIGHT, h);
	endtask : setup

	// Select the operation, then start through the control register.
	task automatic run(input logic [31:0] op, ctl);
		apb(1'b1, `BMT_OFS_OPERATION, op);
		apb(1'b1, `BMT_OFS_CONTROL, ctl);
	endtask : run

	// Poll the active flag until it clears, at most 100 reads.
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, `BMT_OFS_STATUS, 32'h0);
			n++;
		end while (rd_q[0] !== 1'b0 && n < 100);
		check("engine idle", {31'h0, rd_q[0]}, 32'h0);
	endtask : wait_idle

	// Expected raster result: each bit picks rop[{src, dst}].
	function automatic logic [15:0] rop_of(input logic [3:0] r,
		input logic [15:0] s, input logic [15:0] d);
		logic [15:0] y;
		for (int i = 0; i < 16; i++)
			y[i] = r[{s[i], d[i]}];
		return y;
	endfunction : rop_of

	// Print the counts and the verdict, then stop.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// Cut a hang short; the tests need far fewer cycles.
	initial begin
		#(100 * 60000);
		mismatches++;
		test_done();
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 16'h0;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Parameter registers clear at reset and keep what is written.
		foreach (reg_list[i]) begin
			apb(1'b0, reg_list[i], 32'h0);
			check("reset value", rd_q, `BMT_REG_RESET);
			apb(1'b1, reg_list[i], 32'h155);
			apb(1'b0, reg_list[i], 32'h0);
			check("read back", rd_q, 32'h155);
		end
		apb(1'b1, `BMT_OFS_OPERATION, 32'h000c_0002);
		apb(1'b0, `BMT_OFS_OPERATION, 32'h0);
		check("operation", rd_q, 32'h000c_0002);
		apb(1'b0, 16'h8200, 32'h0);
		check("unmapped", {err_q, rd_q[30:0]}, 32'h8000_0000);
		// Every raster code on a single 16 bpp pixel.
		setup(32'h10, 32'h20, 32'h0, 32'h0, 32'h0);
		for (int r = 0; r < 16; r++) begin
			mem_u.mem[8] = 16'h5a3c;
			mem_u.mem[16] = 16'h0ff0;
			run({12'h0, r[3:0], 12'h0, `BMT_OPC_MOVE_POS}, 32'h0004_0001);
			wait_idle();
			check("rop", {16'h0, mem_u.mem[16]},
				{16'h0, rop_of(r[3:0], 16'h5a3c, 16'h0ff0)});
		end
		apb(1'b0, `BMT_OFS_CONTROL, 32'h0);
		check("start bit", {31'h0, rd_q[0]}, 32'h0);
		// Rectangle 2x2 with stride 8 words copied to a linear run.
		for (int i = 0; i < 5; i++) begin
			mem_u.mem[128 + 8 * (i / 2) + i % 2] = 16'h1000 + 16'(i);
			mem_u.mem[192 + i] = 16'hdead;
		end
		setup(32'h100, 32'h180, 32'h8, 32'h1, 32'h1);
		run(32'h000c_0002, 32'h0004_0003);
		wait_idle();
		for (int i = 0; i < 4; i++)
			check("move", mem_u.mem[192 + i], 32'h1000 + i);
		check("beyond", mem_u.mem[196], 32'hdead);
		// Overlapping linear move backward, slow memory.
		slow <= 1'b1;
		for (int i = 0; i < 5; i++)
			mem_u.mem[64 + i] = 16'h2000 + 16'(i);
		setup(32'h86, 32'h88, 32'h0, 32'h3, 32'h0);
		run(32'h000c_0003, 32'h0004_0007);
		wait_idle();
		for (int i = 0; i < 4; i++)
			check("back", mem_u.mem[65 + i], 32'h2000 + i);
		// 8 bpp transparent write, phase 1, 3x2 pixels in 4 words.
		slow <= 1'b0;
		foreach (tw_idx[i]) mem_u.mem[tw_idx[i]] = 16'hffff;
		setup(32'h1, 32'h200, 32'h8, 32'h2, 32'h1);
		apb(1'b1, `BMT_OFS_BG_COLOUR, 32'h7c);
		run(32'h0000_0004, 32'h0000_0001);
		apb(1'b0, `BMT_OFS_STATUS, 32'h0);
		check("fifo empty", {25'h0, rd_q[6:0]}, 32'h1);
		foreach (tw_data[i]) begin
			apb(1'b0, `BMT_OFS_STATUS, 32'h0);
			check("active", {31'h0, rd_q[0]}, 32'h1);
			apb(1'b1, `BMT_OFS_DATA_PORT, {16'h0, tw_data[i]});
		end
		wait_idle();
		foreach (tw_idx[i])
			check("twrite", mem_u.mem[tw_idx[i]], tw_exp[i]);
		// 16 bpp transparent write of two pixels, the second one keyed.
		mem_u.mem[288] = 16'hffff;
		mem_u.mem[289] = 16'hffff;
		setup(32'h0, 32'h240, 32'h0, 32'h1, 32'h0);
		apb(1'b1, `BMT_OFS_BG_COLOUR, 32'h1234);
		run(32'h0000_0004, 32'h0004_0001);
		apb(1'b1, `BMT_OFS_DATA_PORT, 32'h0000_abcd);
		apb(1'b1, `BMT_OFS_DATA_PORT, 32'h0000_1234);
		wait_idle();
		check("tw16", {mem_u.mem[289], mem_u.mem[288]},
			32'hffff_abcd);
		// 8 bpp move of two bytes from an odd source address.
		mem_u.mem[384] = 16'h2211;
		mem_u.mem[385] = 16'h4433;
		mem_u.mem[416] = 16'hffff;
		setup(32'h301, 32'h340, 32'h0, 32'h1, 32'h0);
		run(32'h000c_0002, 32'h0000_0001);
		wait_idle();
		check("move8", mem_u.mem[416], 32'h3322);
		apb(1'b0, `BMT_OFS_DATA_PORT, 32'h0);
		check("port read", rd_q, 32'h0);
		test_done();
	end
endmodule : bmt_engine_tb_top

// ==== tb/bmt_mem_model.sv ====
`timescale 1ns/1ns
// Display memory behind the engine, 512 words, prompt or slow answers.
module bmt_mem_model (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  slow,	// Adds three wait cycles.
	input wire logic                  mem_valid,
	input wire bmt_pkg::bmt_mem_cmd_t mem_cmd,
	output logic                      mem_ack,
	output logic [15:0]               mem_rdata
);
	logic [15:0] mem [512];	// Word storage, preloaded by the bench.
	logic [1:0]  wait_cnt;	// Cycles spent on the current command.
	logic [15:0] rd_q;	// Word taken by the last answer.
	logic [8:0]  idx;	// Word index of the command.
	logic        go;	// Command is answered at this edge.
	assign idx = mem_cmd.addr[9:1];
	assign go = mem_valid && !mem_ack && (!slow || wait_cnt == 2'h3);
	// Count wait cycles and pulse the acknowledge for one cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			mem_ack <= go;
			wait_cnt <= (go || !mem_valid) ? 2'h0 : wait_cnt + 2'h1;
		end
	end
	// Storage is not reset; only enabled byte lanes are written.
	always @(posedge clk) begin
		if (go && mem_cmd.we && mem_cmd.be[0])
			mem[idx][7:0] <= mem_cmd.wdata[7:0];
		if (go && mem_cmd.we && mem_cmd.be[1])
			mem[idx][15:8] <= mem_cmd.wdata[15:8];
		if (go)
			rd_q <= mem[idx];
	end
	// Outside the answer the bus shows the inverse of the last word.
	assign mem_rdata = mem_ack ? rd_q : ~rd_q;
endmodule : bmt_mem_model
